/* design/spi_client_cfg.svh */
// register map, field positions, reset values and timing counts of the serial port
// assumes byte addressing on a 32-bit classic wishbone bus
`ifndef SPI_CLIENT_CFG_SVH
`define SPI_CLIENT_CFG_SVH

// register byte offsets
`define ADDR_CTRL 4'h0
`define ADDR_STATUS 4'h4
`define ADDR_DATA 4'h8

// control register fields
`define CTRL_EN_BIT 0
`define CTRL_MODE_LSB 1
`define CTRL_MODE_MSB 4
`define CTRL_CPOL_BIT 5
`define CTRL_CKE_BIT 6
`define CTRL_PHASE_BIT 7
`define CTRL_BUFFER_OVERWRITE_ENABLE_BIT 8
`define CTRL_INTEN_BIT 9
`define CTRL_WIDTH 10
`define CTRL_RESET 10'h000

// status register fields
`define STAT_BF_BIT 0
`define STAT_WRITE_COLLISION_FLAG_BIT 1
`define STAT_DONE_BIT 2
`define STAT_BUSY_BIT 3
`define STAT_SS_BIT 4

// mode select field encodings
`define MODE_HOST 4'h0
`define MODE_CLIENT_SS 4'h4
`define MODE_CLIENT 4'h5

// counts
`define BYTE_BITS 4'h8
`define HOST_HALF_CYCLES 8'h02
`define HOST_TOGGLES 5'h10
`define DATA_RESET 8'h00

`endif

/* design/spi_client_pkg.sv */
// types shared by the serial port design
// assumes nothing of its surroundings
package spi_client_pkg;

  // host-mode clock generator states
  typedef enum {HOST_IDLE, HOST_RUN} host_state_type;

endpackage

/* design/spi_client_serial_port.sv */
// spi serial port with client shift engine, select framing and a small host mode
// assumes a classic wishbone master on clk_i and spi pins from another clock domain
//
// Chosen here: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`include "spi_client_cfg.svh"

// Summary of operation
// - client mode shifts only on sck edges supplied by the host
// - transfer done flag rises once the eighth bit is latched
// - client shifting follows sck alone, independent of sleep
// - a byte received during sleep sets the flag and wakes if enabled
// - daisy chain: bits received are shifted out on the next byte
// - overwrite enable lets a new byte replace an unread buffer
// - select falling starts a new client transfer
// - select rising resets receive state, ready for next fall
// - bit counter clears when select is high or port is disabled
// - select pin matters only with mode select field 0100
// - select low with select control enables shifting and drives sdo
// - select high releases sdo three clocks later, even mid byte
// - host mode sleep freezes the transfer, wake resumes it
// - msb first; eighth bit copies byte to buffer, sets full and done
// - buffer write during transfer is dropped and sets write collision
// - reading the data buffer clears buffer full
module spi_client_serial_port (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sleep_i,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_o,
  input wire logic sdi_i,
  input wire logic ss_n_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  output logic wake_o
);

  logic [`CTRL_WIDTH-1:0] ctrl_reg;
  logic [7:0] shift_register;
  logic [7:0] data_buffer;
  logic [3:0] bit_cnt_reg;
  logic buffer_full_flag;
  logic write_collision_flag;
  logic transfer_done_flag;
  logic sck_s;
  logic sdi_s;
  logic ss_n_s;
  logic ss_n_prev_reg;
  logic sck_prev_reg;
  logic host_sck_reg;
  logic [7:0] half_cnt_reg;
  logic [4:0] toggle_cnt_reg;
  spi_client_pkg::host_state_type host_state_reg;

  logic port_enable_bit;
  logic [3:0] mode_select_field;
  logic clock_polarity_bit;
  logic clock_edge_bit;
  logic buffer_overwrite_enable;
  logic int_enable_bit;
  logic host_mode;
  logic ss_mode;
  logic shift_enable;
  logic sck_now;
  logic lead_edge;
  logic trail_edge;
  logic in_edge;
  logic out_edge;
  logic byte_done;
  logic busy;
  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic data_wr;
  logic data_wr_ok;
  logic status_wr;
  logic ctrl_idle;
  logic [31:0] rd_mux;

  // control fields
  assign port_enable_bit = ctrl_reg[`CTRL_EN_BIT];
  assign mode_select_field = ctrl_reg[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
  assign clock_polarity_bit = ctrl_reg[`CTRL_CPOL_BIT];
  assign clock_edge_bit = ctrl_reg[`CTRL_CKE_BIT];
  assign buffer_overwrite_enable = ctrl_reg[`CTRL_BUFFER_OVERWRITE_ENABLE_BIT];
  assign int_enable_bit = ctrl_reg[`CTRL_INTEN_BIT];
  assign host_mode = (mode_select_field == `MODE_HOST);
  assign ss_mode = (mode_select_field == `MODE_CLIENT_SS);

  // pins pass two flops before any logic reads them
  spi_sync2 #(.RST_VAL(1'b0)) u_sync_sck (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(sck_i),
    .q_o(sck_s)
  );

  spi_sync2 #(.RST_VAL(1'b0)) u_sync_sdi (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(sdi_i),
    .q_o(sdi_s)
  );

  spi_sync2 #(.RST_VAL(1'b1)) u_sync_ss (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(ss_n_i),
    .q_o(ss_n_s)
  );

  // shifting allowed: port on, and in select mode only while select is low
  assign shift_enable = port_enable_bit && (!ss_mode || !ss_n_s);

  // clock source: own generator in host mode, the host's sck otherwise
  assign sck_now = host_mode ? host_sck_reg : sck_s;

  // leading edge leaves the idle level, trailing edge returns to it
  assign lead_edge = (sck_prev_reg == clock_polarity_bit) && (sck_now != clock_polarity_bit);
  assign trail_edge = (sck_prev_reg != clock_polarity_bit) && (sck_now == clock_polarity_bit);

  // clock edge bit set: sample on leading, drive on trailing edge
  assign in_edge = shift_enable && (clock_edge_bit ? lead_edge : trail_edge);
  assign out_edge = shift_enable && (clock_edge_bit ? trail_edge : lead_edge);
  assign byte_done = in_edge && (bit_cnt_reg == `BYTE_BITS - 4'h1);

  // a transfer counts as running once any bit has moved or host clock runs
  assign busy = (bit_cnt_reg != 4'h0) || (host_state_reg == spi_client_pkg::HOST_RUN);

  // bus decode; a request is acted on in the cycle before ack rises
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr = bus_req && wb_we_i;
  assign bus_rd = bus_req && !wb_we_i;
  assign data_wr = bus_wr && (wb_adr_i == `ADDR_DATA) && wb_sel_i[0];
  assign status_wr = bus_wr && (wb_adr_i == `ADDR_STATUS) && wb_sel_i[0];
  assign data_wr_ok = data_wr && !busy && !write_collision_flag;
  assign ctrl_idle = !busy;

  // edge history of the chosen clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_prev_reg <= 1'b0;
      ss_n_prev_reg <= 1'b1;
    end else begin
      sck_prev_reg <= sck_now;
      ss_n_prev_reg <= ss_n_s;
    end
  end

  // control register, byte lanes honoured
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `CTRL_RESET;
    end else if (bus_wr && (wb_adr_i == `ADDR_CTRL)) begin
      if (wb_sel_i[0]) begin
        ctrl_reg[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        ctrl_reg[9:8] <= wb_dat_i[9:8];
      end
    end
  end

  // bit counter: cleared by select high or port disable, and after each byte
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bit_cnt_reg <= 4'h0;
    end else if (!port_enable_bit || (ss_mode && ss_n_s)) begin
      bit_cnt_reg <= 4'h0;
    end else if (ss_mode && ss_n_prev_reg && !ss_n_s) begin
      bit_cnt_reg <= 4'h0;
    end else if (byte_done) begin
      bit_cnt_reg <= 4'h0;
    end else if (in_edge) begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  // shift register: msb leaves first, sdi enters at the bottom;
  // left alone after a byte, it replays the received byte for a daisy chain
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shift_register <= `DATA_RESET;
    end else if (data_wr_ok) begin
      shift_register <= wb_dat_i[7:0];
    end else if (in_edge) begin
      shift_register <= {shift_register[6:0], sdi_s};
    end
  end

  // sdo data: msb presented on load and refreshed on every drive edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sdo_o <= 1'b0;
    end else if (data_wr_ok) begin
      sdo_o <= wb_dat_i[7];
    end else if (out_edge || (ss_mode && ss_n_prev_reg && !ss_n_s)) begin
      sdo_o <= shift_register[7];
    end
  end

  // sdo enable; select high floats it at once even mid byte.
  // limitation: the pin passes the synchroniser, so release lags by three clocks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sdo_oe_o <= 1'b0;
    end else if (ss_mode) begin
      sdo_oe_o <= port_enable_bit && !ss_n_s;
    end else begin
      sdo_oe_o <= port_enable_bit;
    end
  end

  // receive buffer: a finished byte lands unless the old one is unread and overwrite is off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_buffer <= `DATA_RESET;
    end else if (byte_done && (!buffer_full_flag || buffer_overwrite_enable)) begin
      data_buffer <= {shift_register[6:0], sdi_s};
    end
  end

  // buffer full: set wins over a read clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buffer_full_flag <= 1'b0;
    end else if (byte_done) begin
      buffer_full_flag <= 1'b1;
    end else if (bus_rd && (wb_adr_i == `ADDR_DATA)) begin
      buffer_full_flag <= 1'b0;
    end
  end

  // transfer done: set by the eighth latched bit, write one to clear;
  // counted in the clk domain even while asleep so the flag can wake the core
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      transfer_done_flag <= 1'b0;
    end else if (byte_done) begin
      transfer_done_flag <= 1'b1;
    end else if (status_wr && wb_dat_i[`STAT_DONE_BIT]) begin
      transfer_done_flag <= 1'b0;
    end
  end

  // write collision: a data write while busy or while set is dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      write_collision_flag <= 1'b0;
    end else if (data_wr && busy) begin
      write_collision_flag <= 1'b1;
    end else if (status_wr && wb_dat_i[`STAT_WRITE_COLLISION_FLAG_BIT]) begin
      write_collision_flag <= 1'b0;
    end
  end

  // wake request follows the done flag when the interrupt is enabled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= transfer_done_flag && int_enable_bit;
    end
  end

  // host clock generator; sleep stops the divider so the byte freezes in place
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      host_state_reg <= spi_client_pkg::HOST_IDLE;
      host_sck_reg <= 1'b0;
      half_cnt_reg <= 8'h00;
      toggle_cnt_reg <= 5'h00;
    end else if (!port_enable_bit || !host_mode) begin
      host_state_reg <= spi_client_pkg::HOST_IDLE;
      host_sck_reg <= clock_polarity_bit;
      half_cnt_reg <= 8'h00;
      toggle_cnt_reg <= 5'h00;
    end else begin
      unique case (host_state_reg)
        spi_client_pkg::HOST_IDLE: begin
          host_sck_reg <= clock_polarity_bit;
          if (data_wr_ok) begin
            host_state_reg <= spi_client_pkg::HOST_RUN;
            half_cnt_reg <= 8'h00;
            toggle_cnt_reg <= 5'h00;
          end
        end
        spi_client_pkg::HOST_RUN: begin
          if (!sleep_i) begin
            if (half_cnt_reg == `HOST_HALF_CYCLES - 8'h01) begin
              half_cnt_reg <= 8'h00;
              host_sck_reg <= !host_sck_reg;
              toggle_cnt_reg <= toggle_cnt_reg + 5'h01;
              if (toggle_cnt_reg == `HOST_TOGGLES - 5'h01) begin
                host_state_reg <= spi_client_pkg::HOST_IDLE;
              end
            end else begin
              half_cnt_reg <= half_cnt_reg + 8'h01;
            end
          end
        end
      endcase
    end
  end

  // sck pin drive only in host mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_o <= 1'b0;
      sck_oe_o <= 1'b0;
    end else begin
      sck_o <= host_sck_reg;
      sck_oe_o <= port_enable_bit && host_mode;
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (wb_adr_i)
      `ADDR_CTRL: begin
        rd_mux[`CTRL_WIDTH-1:0] = ctrl_reg;
      end
      `ADDR_STATUS: begin
        rd_mux[`STAT_BF_BIT] = buffer_full_flag;
        rd_mux[`STAT_WRITE_COLLISION_FLAG_BIT] = write_collision_flag;
        rd_mux[`STAT_DONE_BIT] = transfer_done_flag;
        rd_mux[`STAT_BUSY_BIT] = !ctrl_idle;
        rd_mux[`STAT_SS_BIT] = ss_n_s;
      end
      `ADDR_DATA: begin
        rd_mux[7:0] = data_buffer;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // one-wait-state ack for every address, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_rd) begin
        wb_dat_o <= rd_mux;
      end
    end
  end

endmodule // spi_client_serial_port

/* design/spi_sync2.sv */
// two flip-flop synchroniser for one asynchronous pin
// assumes the reset value matches the idle level of the pin
`timescale 1ns/1ps

module spi_sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic d_i,
  output logic q_o
);

  logic meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end

endmodule // spi_sync2

/* test/spi_client_serial_port_sva.sv */
// concurrent checks on the ports of the spi serial port top
// assumes a single clk_i domain; bound to the design at the foot of this file
`timescale 1ns/1ps

module spi_client_serial_port_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic sleep_i,
  input wire logic sck_i,
  input wire logic sck_o,
  input wire logic sck_oe_o,
  input wire logic ss_n_i,
  input wire logic sdo_o,
  input wire logic sdo_oe_o,
  input wire logic wake_o
);
  logic [3:0] quiet_reg;
  logic sck_last_reg;
  logic ss_last_reg;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // cycles since the last pin event or bus answer, saturating so it never wraps
  always_ff @(posedge clk_i) begin
    sck_last_reg <= sck_i;
    ss_last_reg <= ss_n_i;
    if (rst_i || sck_i != sck_last_reg || ss_n_i != ss_last_reg || wb_ack_o) begin
      quiet_reg <= 4'h0;
    end else if (quiet_reg != 4'hF) begin
      quiet_reg <= quiet_reg + 4'h1;
    end
  end

  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered in the next cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_needs_req: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without a request");
  a_sdo_from_sck: assert property (
    sdo_oe_o && $past(sdo_oe_o) && !sck_oe_o && !$past(sck_oe_o) && $changed(sdo_o)
    |-> quiet_reg <= 4'h7) else $error("sdo moved without an sck edge");
  a_ss_release: assert property ($rose(ss_n_i) |-> ##[1:5] !sdo_oe_o)
    else $error("sdo still driven after deselect");
  a_wake_cause: assert property ($rose(wake_o) |-> quiet_reg <= 4'h7)
    else $error("done flag rose without a recent sck edge");
  a_wake_holds: assert property (wake_o && !wb_cyc_i |=> wake_o)
    else $error("done flag dropped without a bus write");
  a_sleep_freeze: assert property (
    $past(sleep_i) && $past(sleep_i, 2) && sck_oe_o |-> $stable(sck_o))
    else $error("host sck moved during sleep");
endmodule // spi_client_serial_port_sva

bind spi_client_serial_port spi_client_serial_port_sva spi_client_serial_port_sva_inst (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .sleep_i, .sck_i, .sck_o, .sck_oe_o,
  .ss_n_i, .sdo_o, .sdo_oe_o, .wake_o);

/* test/spi_client_serial_port_tb.sv */
// self-checking bench: wishbone read and write tasks plus an spi host model
// assumes a classic wishbone slave that answers every request with one ack pulse
`timescale 1ns/1ps
`include "spi_client_cfg.svh"

module spi_client_serial_port_tb;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, sleep, wb_ack, sck, sck_out, sck_oe;
  logic ss_n, mosi, sdo, sdo_oe, wake;
  logic [3:0] wb_adr;
  logic [31:0] wb_wdat, wb_rdat, rd;
  int mismatches, tests_run, rises, r0;
  // enable, mode 0100, cke set with select control, sample phase clear, int enable
  localparam logic [31:0] CLIENT_SS = 32'h0000_0249;

  spi_client_serial_port spi_client_serial_port_inst (
    .clk_i, .rst_i, .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .sleep_i(sleep), .sck_i(sck), .sck_o(sck_out), .sck_oe_o(sck_oe),
    .sdi_i(mosi), .ss_n_i(ss_n), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .wake_o(wake));
  spi_host_model spi_host_model_inst (
    .sck_o(sck), .ss_n_o(ss_n), .mosi_o(mosi), .sdo_i(sdo), .sdo_oe_i(sdo_oe));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge sck_out) rises++;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // one classic cycle; request held until ack is sampled high at a rising edge
  task automatic bus(input logic [3:0] adr, input logic we, input logic [31:0] wd);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wdat <= wd;
    // ack and read data are taken at the rising edge, before the design updates them
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      $display("unexpected at %0t: no bus answer", $time);
    end
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rchk(input logic [3:0] adr, input logic [31:0] exp);
    bus(adr, 1'b0, 32'h0);
    check(rd, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // whole run is about 19 us; this limit only trips on a hang
  initial begin
    #300us;
    mismatches++;
    $display("unexpected at %0t: run did not finish", $time);
    report_and_stop;
  end

  initial begin
    {rst_i, wb_cyc, wb_stb, wb_we, sleep, wb_adr, wb_wdat} = {1'b1, 40'h0};
    {mismatches, tests_run, rises} = '0;
    idle(12);
    rst_i <= 1'b0;
    idle(1);
    // reset values and an unmapped address
    rchk(`ADDR_CTRL, {22'h0, `CTRL_RESET});
    rchk(`ADDR_STATUS, 32'h10);
    rchk(4'hC, 32'h0);
    check({sdo_oe, sck_oe, wake}, 3'b000);
    $display("test reset finished");
    // exchange while asleep, then daisy-chain replay and overwrite
    bus(`ADDR_CTRL, 1'b1, CLIENT_SS);
    bus(`ADDR_DATA, 1'b1, 32'hA5);
    sleep <= 1'b1;
    spi_host_model_inst.frame(8'h3C, 8, 1'b1);
    idle(8);
    check(spi_host_model_inst.rx_reg, 8'hA5);
    check(spi_host_model_inst.oe_seen_reg, 1'b1);
    check(wake, 1'b1);
    check(sck_oe, 1'b0);
    sleep <= 1'b0;
    rchk(`ADDR_STATUS, 32'h15);
    rchk(`ADDR_DATA, 32'h3C);
    rchk(`ADDR_STATUS, 32'h14);
    spi_host_model_inst.frame(8'h5A, 8, 1'b1);
    idle(8);
    check(spi_host_model_inst.rx_reg, 8'h3C);
    spi_host_model_inst.frame(8'h11, 8, 1'b1);
    idle(8);
    rchk(`ADDR_DATA, 32'h5A);
    spi_host_model_inst.frame(8'h22, 8, 1'b1);
    idle(8);
    bus(`ADDR_CTRL, 1'b1, CLIENT_SS | 32'h100);
    spi_host_model_inst.frame(8'h33, 8, 1'b1);
    idle(8);
    rchk(`ADDR_DATA, 32'h33);
    $display("test exchange finished");
    // buffer write in mid byte is dropped and flagged
    fork
      spi_host_model_inst.frame(8'h44, 8, 1'b1);
      begin
        idle(45);
        bus(`ADDR_DATA, 1'b1, 32'h77);
      end
    join
    idle(8);
    check(spi_host_model_inst.rx_reg, 8'h33);
    rchk(`ADDR_STATUS, 32'h17);
    bus(`ADDR_STATUS, 1'b1, 32'h6);
    rchk(`ADDR_STATUS, 32'h11);
    check(wake, 1'b0);
    // aborted frame: deselect clears the bit count so a buffer write is accepted
    spi_host_model_inst.frame(8'hFF, 3, 1'b1);
    idle(8);
    rchk(`ADDR_STATUS, 32'h11);
    bus(`ADDR_DATA, 1'b1, 32'h81);
    spi_host_model_inst.frame(8'h96, 8, 1'b1);
    idle(8);
    check(spi_host_model_inst.rx_reg, 8'h81);
    rchk(`ADDR_DATA, 32'h96);
    // mode 0101 ignores the select pin
    bus(`ADDR_CTRL, 1'b1, 32'h0B);
    spi_host_model_inst.frame(8'h69, 8, 1'b0);
    idle(8);
    rchk(`ADDR_DATA, 32'h69);
    $display("test framing finished");
    // host mode: sleep freezes the byte, waking resumes it
    bus(`ADDR_STATUS, 1'b1, 32'h4);
    bus(`ADDR_CTRL, 1'b1, 32'h01);
    rises = 0;
    bus(`ADDR_DATA, 1'b1, 32'h81);
    sleep <= 1'b1;
    idle(2);
    r0 = rises;
    idle(20);
    check(rises, r0);
    sleep <= 1'b0;
    idle(60);
    check(rises, 8);
    rchk(`ADDR_STATUS, 32'h15);
    $display("test host finished");
    report_and_stop;
  end
endmodule // spi_client_serial_port_tb

/* test/spi_host_model.sv */
// behavioural spi host: drives sck, select and serial data, samples sdo
// assumes clock polarity 0; sck stands still between frames
`timescale 1ns/1ps

module spi_host_model (
  output logic sck_o,
  output logic ss_n_o,
  output logic mosi_o,
  input wire logic sdo_i,
  input wire logic sdo_oe_i
);
  logic [7:0] rx_reg;
  logic oe_seen_reg;

  // sck idles low to match clock polarity 0 before the port is enabled
  initial begin
    sck_o = 1'b0;
    ss_n_o = 1'b1;
    mosi_o = 1'b1;
  end

  // one frame of nbits, msb first, 160 ns sck period, sampling on the rising edge;
  // mosi changes mid low phase so a leading or a trailing sample edge sees it settled
  task automatic frame(input logic [7:0] tx, input int nbits, input logic use_ss);
    ss_n_o = !use_ss;
    oe_seen_reg = 1'b1;
    #203;
    for (int i = 7; i > 7 - nbits; i--) begin
      #40 mosi_o = tx[i];
      #40 sck_o = 1'b1;
      // a floating sdo reads as the inverse, never as the last driven bit
      rx_reg = {rx_reg[6:0], sdo_oe_i ? sdo_i : !sdo_i};
      oe_seen_reg = oe_seen_reg & sdo_oe_i;
      #80 sck_o = 1'b0;
    end
    #200 ss_n_o = 1'b1;
    mosi_o = ~mosi_o; // released line must not keep the last bit
  endtask
endmodule // spi_host_model
